// *** verilog/dacr_defines.vh ***
// register map, field positions and codes for the dac output stage control bank
`ifndef DACR_DEFINES_VH
`define DACR_DEFINES_VH
`define DACR_OFS_PWR        10'h025
`define DACR_OFS_DRV        10'h026
`define DACR_OFS_RSVD       10'h027
`define DACR_OFS_STAGE      10'h028
`define DACR_OFS_SWITCH     10'h029
`define DACR_OFS_LVOL       10'h02b
`define DACR_OFS_RVOL       10'h02c
`define DACR_OFS_STATUS     10'h030
`define DACR_NUM_CH         2
`define DACR_ADDR_SHIFT     2
`define DACR_PWR_MASK       8'hf0
`define DACR_DRV_MASK       8'h3e
`define DACR_SW_MASK        8'hf3
`define DACR_VOL_MASK       8'h7f
`define DACR_RST8           8'h00
`define DACR_LEFT_HEADPHONE_COMMON_OUT_RSVD    2'h3
`define DACR_RIGHT_HEADPHONE_COMMON_OUT_MAX     3'h4
`define DACR_STEP_FS        2'h0
`define DACR_STEP_2FS       2'h1
`define DACR_STEP_OFF       2'h2
`define DACR_STEP_RSVD      2'h3
`define DACR_PATH_RSVD      2'h3
`define DACR_PATH_DIRECT    2'h2
`define DACR_LINK_L_FROM_R  2'h1
`define DACR_LINK_R_FROM_L  2'h2
`define DACR_DIRECT_TRIM_DB 8'h01
`endif

// *** verilog/dacr_vol_step.v ***
// one channel volume follower that walks toward its target by single steps, or takes it at once when bypassed
`timescale 1ns/10ps
`default_nettype none
`include "dacr_defines.vh"
module dacr_vol_step #(
  parameter W = 7
) (
  input  wire         i_clk,
  input  wire         i_sys_rst,
  input  wire         i_tick,
  input  wire         i_bypass,
  input  wire [W-1:0] i_target,
  output wire [W-1:0] o_level
);
  reg [W-1:0] level_ff;
  reg [W-1:0] nxt_level;

  always @* begin
    nxt_level = level_ff;
    if (i_bypass) begin
      nxt_level = i_target;
    end else if (i_tick && (level_ff < i_target)) begin
      nxt_level = level_ff + {{(W-1){1'b0}}, 1'b1};
    end else if (i_tick && (level_ff > i_target)) begin
      nxt_level = level_ff - {{(W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      level_ff <= {W{1'b0}};
    end else begin
      level_ff <= nxt_level;
    end
  end

  assign o_level = level_ff;
endmodule
`default_nettype wire

// *** verilog/dacr_regs.v ***
// apb register bank for dac power, output driver and path switching control
`timescale 1ns/10ps
`default_nettype none
`include "dacr_defines.vh"
module dacr_regs #(
  parameter VW = 7
) (
  input  wire          i_clk,
  input  wire          i_sys_rst,
  input  wire          i_psel,
  input  wire          i_penable,
  input  wire          i_pwrite,
  input  wire [11:0]   i_paddr,
  input  wire [31:0]   i_pwdata,
  input  wire          i_fs_tick,
  output reg  [31:0]   o_prdata,
  output reg           o_pready,
  output reg           o_pslverr,
  output reg           o_left_dac_pwr,
  output reg           o_right_dac_pwr,
  output reg  [1:0]    o_left_headphone_common_out_cfg,
  output reg  [2:0]    o_right_headphone_common_out_cfg,
  output reg           o_short_prot_en,
  output reg           o_short_prot_pwrdn,
  output reg  [1:0]    o_out_cm_sel,
  output reg  [1:0]    o_second_left_line_input_bypass,
  output reg  [1:0]    o_second_right_line_input_bypass,
  output reg  [1:0]    o_left_dac_path_sel,
  output reg  [1:0]    o_right_dac_path_sel,
  output reg  [7:0]    o_left_direct_trim_db,
  output reg  [7:0]    o_right_direct_trim_db,
  output reg  [VW-1:0] o_left_dac_vol,
  output reg  [VW-1:0] o_right_dac_vol
);
  localparam NCH = `DACR_NUM_CH;
  reg  [7:0]    pwr_ff;
  reg  [7:0]    drv_ff;
  reg  [7:0]    stage_ff;
  reg  [7:0]    switch_ff;
  reg  [7:0]    lvol_ff;
  reg  [7:0]    rvol_ff;
  reg           half_ff;
  reg           rsvd_hit_ff;
  reg  [7:0]    nxt_pwr;
  reg  [7:0]    nxt_drv;
  reg  [7:0]    nxt_stage;
  reg  [7:0]    nxt_switch;
  reg  [31:0]   nxt_rdata;
  reg           nxt_err;
  reg           nxt_rsvd_hit;
  reg  [31:0]   nxt_prdata;
  reg           nxt_pslverr;
  reg  [7:0]    nxt_lvol;
  reg  [7:0]    nxt_rvol;
  wire [9:0]    idx;
  wire          wr_acc;
  wire          acc;
  wire          setup;
  wire [7:0]    wd;
  wire          tick;
  wire          step_off;
  wire [VW-1:0] lvol_target;
  wire [VW-1:0] rvol_target;
  wire [VW-1:0] lvol_level;
  wire [VW-1:0] rvol_level;
  wire [NCH*VW-1:0] vol_target;
  wire [NCH*VW-1:0] vol_level;
  genvar        ch;

  assign idx    = i_paddr[11:`DACR_ADDR_SHIFT];
  assign acc    = i_psel && i_penable && o_pready;
  assign wr_acc = acc && i_pwrite;
  assign setup  = i_psel && !i_penable;
  assign wd     = i_pwdata[7:0];

  // forbidden codes are refused field by field so the outputs never see them
  always @* begin
    nxt_pwr      = pwr_ff;
    nxt_drv      = drv_ff;
    nxt_stage    = stage_ff;
    nxt_switch   = switch_ff;
    nxt_err      = 1'b0;
    nxt_rsvd_hit = rsvd_hit_ff;
    case (idx)
      `DACR_OFS_PWR: begin
        nxt_pwr[7:6] = wd[7:6];
        if (wd[5:4] != `DACR_LEFT_HEADPHONE_COMMON_OUT_RSVD) begin
          nxt_pwr[5:4] = wd[5:4];
        end else begin
          nxt_err = 1'b1;
        end
        nxt_pwr = nxt_pwr & `DACR_PWR_MASK;
      end
      `DACR_OFS_DRV: begin
        if (wd[5:3] <= `DACR_RIGHT_HEADPHONE_COMMON_OUT_MAX) begin
          nxt_drv[5:3] = wd[5:3];
        end else begin
          nxt_err = 1'b1;
        end
        nxt_drv[2:1] = wd[2:1];
        nxt_drv = nxt_drv & `DACR_DRV_MASK;
      end
      `DACR_OFS_RSVD: begin
        nxt_err      = 1'b1;
        nxt_rsvd_hit = 1'b1;
      end
      `DACR_OFS_STAGE: begin
        nxt_stage[7:2] = wd[7:2];
        if (wd[1:0] != `DACR_STEP_RSVD) begin
          nxt_stage[1:0] = wd[1:0];
        end else begin
          nxt_err = 1'b1;
        end
      end
      `DACR_OFS_SWITCH: begin
        if (wd[7:6] != `DACR_PATH_RSVD) begin
          nxt_switch[7:6] = wd[7:6];
        end else begin
          nxt_err = 1'b1;
        end
        if (wd[5:4] != `DACR_PATH_RSVD) begin
          nxt_switch[5:4] = wd[5:4];
        end else begin
          nxt_err = 1'b1;
        end
        nxt_switch[1:0] = wd[1:0];
        nxt_switch = nxt_switch & `DACR_SW_MASK;
      end
      `DACR_OFS_LVOL, `DACR_OFS_RVOL: begin
        nxt_err = 1'b0;
      end
      default: begin
        nxt_err = 1'b1;
      end
    endcase
    // only a completed write access may change the stored fields
    if (!wr_acc) begin
      nxt_pwr      = pwr_ff;
      nxt_drv      = drv_ff;
      nxt_stage    = stage_ff;
      nxt_switch   = switch_ff;
      nxt_rsvd_hit = rsvd_hit_ff;
    end
  end

  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (idx)
      `DACR_OFS_PWR:    nxt_rdata[7:0] = pwr_ff;
      `DACR_OFS_DRV:    nxt_rdata[7:0] = drv_ff;
      `DACR_OFS_RSVD:   nxt_rdata[7:0] = `DACR_RST8;
      `DACR_OFS_STAGE:  nxt_rdata[7:0] = stage_ff;
      `DACR_OFS_SWITCH: nxt_rdata[7:0] = switch_ff;
      `DACR_OFS_LVOL:   nxt_rdata[7:0] = lvol_ff;
      `DACR_OFS_RVOL:   nxt_rdata[7:0] = rvol_ff;
      `DACR_OFS_STATUS: nxt_rdata[15:0] = {rsvd_hit_ff, lvol_level, rvol_level, 1'b0};
      default:          nxt_rdata = 32'h0000_0000;
    endcase
  end

  // setup cycle prepares the answer so ready, error and data all stand in the access cycle
  always @* begin
    nxt_prdata  = o_prdata;
    nxt_pslverr = 1'b0;
    nxt_lvol    = lvol_ff;
    nxt_rvol    = rvol_ff;
    if (setup) begin
      nxt_prdata  = i_pwrite ? 32'h0000_0000 : nxt_rdata;
      nxt_pslverr = i_pwrite ? nxt_err :
                    ((idx > `DACR_OFS_STATUS) || (idx < `DACR_OFS_PWR));
    end
    if (wr_acc && (idx == `DACR_OFS_LVOL)) begin
      nxt_lvol = wd & `DACR_VOL_MASK;
    end
    if (wr_acc && (idx == `DACR_OFS_RVOL)) begin
      nxt_rvol = wd & `DACR_VOL_MASK;
    end
  end

  // pready drops after each access so every transfer takes exactly one wait-free access cycle
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      pwr_ff      <= `DACR_RST8;
      drv_ff      <= `DACR_RST8;
      stage_ff    <= `DACR_RST8;
      switch_ff   <= `DACR_RST8;
      lvol_ff     <= `DACR_RST8;
      rvol_ff     <= `DACR_RST8;
      rsvd_hit_ff <= 1'b0;
      o_prdata    <= 32'h0000_0000;
      o_pready    <= 1'b0;
      o_pslverr   <= 1'b0;
    end else begin
      pwr_ff      <= nxt_pwr;
      drv_ff      <= nxt_drv;
      stage_ff    <= nxt_stage;
      switch_ff   <= nxt_switch;
      lvol_ff     <= nxt_lvol;
      rvol_ff     <= nxt_rvol;
      rsvd_hit_ff <= nxt_rsvd_hit;
      o_prdata    <= nxt_prdata;
      o_pready    <= setup;
      o_pslverr   <= nxt_pslverr;
    end
  end

  // soft-step tick: every frame tick or every second one; off means immediate
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      half_ff <= 1'b0;
    end else begin
      half_ff <= half_ff ^ i_fs_tick;
    end
  end

  assign step_off = (stage_ff[1:0] == `DACR_STEP_OFF);
  assign tick = i_fs_tick &&
                ((stage_ff[1:0] == `DACR_STEP_FS) || half_ff);

  // linking chooses which channel field each dac follows
  assign lvol_target = (switch_ff[1:0] == `DACR_LINK_L_FROM_R) ?
                       rvol_ff[VW-1:0] : lvol_ff[VW-1:0];
  assign rvol_target = (switch_ff[1:0] == `DACR_LINK_R_FROM_L) ?
                       lvol_ff[VW-1:0] : rvol_ff[VW-1:0];

  assign vol_target = {rvol_target, lvol_target};
  assign lvol_level = vol_level[VW-1:0];
  assign rvol_level = vol_level[VW +: VW];

  // one follower per channel, both paced by the same tick so linked channels move together
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_step
      dacr_vol_step #(
        .W (VW)
      ) u_step (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_tick    (tick),
        .i_bypass  (step_off),
        .i_target  (vol_target[ch*VW +: VW]),
        .o_level   (vol_level[ch*VW +: VW])
      );
    end
  endgenerate

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_left_dac_pwr                   <= 1'b0;
      o_right_dac_pwr                  <= 1'b0;
      o_left_headphone_common_out_cfg  <= 2'h0;
      o_right_headphone_common_out_cfg <= 3'h0;
      o_short_prot_en                  <= 1'b0;
      o_short_prot_pwrdn               <= 1'b0;
      o_out_cm_sel                     <= 2'h0;
      o_second_left_line_input_bypass  <= 2'h0;
      o_second_right_line_input_bypass <= 2'h0;
      o_left_dac_path_sel              <= 2'h0;
      o_right_dac_path_sel             <= 2'h0;
      o_left_direct_trim_db            <= 8'h00;
      o_right_direct_trim_db           <= 8'h00;
      o_left_dac_vol                   <= {VW{1'b0}};
      o_right_dac_vol                  <= {VW{1'b0}};
    end else begin
      o_left_dac_pwr                   <= pwr_ff[7];
      o_right_dac_pwr                  <= pwr_ff[6];
      o_left_headphone_common_out_cfg  <= pwr_ff[5:4];
      o_right_headphone_common_out_cfg <= drv_ff[5:3];
      o_short_prot_en                  <= drv_ff[2];
      o_short_prot_pwrdn               <= drv_ff[2] && drv_ff[1];
      o_out_cm_sel                     <= stage_ff[7:6];
      o_second_left_line_input_bypass  <= stage_ff[5:4];
      o_second_right_line_input_bypass <= stage_ff[3:2];
      o_left_dac_path_sel              <= switch_ff[7:6];
      o_right_dac_path_sel             <= switch_ff[5:4];
      o_left_direct_trim_db  <= (switch_ff[7:6] == `DACR_PATH_DIRECT) ?
                                `DACR_DIRECT_TRIM_DB : 8'h00;
      o_right_direct_trim_db <= (switch_ff[5:4] == `DACR_PATH_DIRECT) ?
                                `DACR_DIRECT_TRIM_DB : 8'h00;
      o_left_dac_vol                   <= lvol_level;
      o_right_dac_vol                  <= rvol_level;
    end
  end
endmodule
`default_nettype wire

// *** verification/dacr_regs_asserts.sv ***
// concurrent checks on the dac output stage register bank ports
`timescale 1ns/10ps
`default_nettype none
module dacr_regs_asserts (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_left_dac_pwr,
  input wire logic        o_right_dac_pwr,
  input wire logic        o_short_prot_en,
  input wire logic        o_short_prot_pwrdn,
  input wire logic [1:0]  o_left_dac_path_sel,
  input wire logic [7:0]  o_left_direct_trim_db
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire acc = i_psel && i_penable && o_pready;
  wire wr_pwr = acc && i_pwrite && i_paddr == 12'h094;
  wire wr_drv = acc && i_pwrite && i_paddr == 12'h098;
  wire at_rsvd = acc && i_paddr == 12'h09c;
  a_zero_wait: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready in first access cycle");
  a_left_pwr_wr: assert property (wr_pwr |-> ##2
    o_left_dac_pwr == $past(i_pwdata[7], 2)) else $error("left dac power not written");
  a_right_pwr_wr: assert property (wr_pwr |-> ##2
    o_right_dac_pwr == $past(i_pwdata[6], 2)) else $error("right dac power not written");
  a_prot_en_wr: assert property (wr_drv |-> ##2
    o_short_prot_en == $past(i_pwdata[2], 2)) else $error("protection enable not written");
  a_prot_mode_wr: assert property (wr_drv |-> ##2
    o_short_prot_pwrdn == $past(i_pwdata[2] & i_pwdata[1], 2))
    else $error("protection mode wrong");
  a_rsvd_reads_zero: assert property (at_rsvd && !i_pwrite |-> o_prdata == 32'h0)
    else $error("reserved register not zero");
  a_rsvd_wr_err: assert property (at_rsvd && i_pwrite |-> o_pslverr)
    else $error("reserved write not refused");
  a_path_code_legal: assert property (o_left_dac_path_sel != 2'h3)
    else $error("left path holds forbidden code");
  a_direct_trim: assert property ($stable(o_left_dac_path_sel) |->
    o_left_direct_trim_db == {7'h0, o_left_dac_path_sel == 2'h2}) else $error("trim mismatch");
  a_reset_clears: assert property ($fell(i_sys_rst) |->
    !o_left_dac_pwr && !o_right_dac_pwr && !o_short_prot_en) else $error("reset left state");
  c_pwr_write: cover property (wr_pwr);
  c_refused: cover property (acc && o_pslverr);
  c_direct_path: cover property (o_left_dac_path_sel == 2'h2);
endmodule
`default_nettype wire

// *** verification/dacr_regs_tb.sv ***
// self-checking bench for the dac output stage register bank
`timescale 1ns/10ps
`default_nettype none
module dacr_regs_tb;
  logic        i_clk = 0, i_sys_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, i_fs_tick = 0;
  logic [11:0] i_paddr = 0, a;
  logic [31:0] i_pwdata = 0, o_prdata, r;
  logic        o_pready, o_pslverr, lp, rp, pe, pd;
  logic [1:0]  lhc, cm, lb, rb, lpa, rpa;
  logic [2:0]  rhc;
  logic [7:0]  lt, rt;
  logic [6:0]  lv, rv;
  logic [7:0]  m [0:7];
  logic [32:0] q [$];
  logic [8:0]  u;
  logic        hit = 1'b0;
  integer      seed = 66, fails = 0, checked = 0, i;
  always #2 i_clk = ~i_clk;
  dacr_regs i_dacr_regs (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .i_fs_tick(i_fs_tick), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_left_dac_pwr(lp), .o_right_dac_pwr(rp), .o_left_headphone_common_out_cfg(lhc),
    .o_right_headphone_common_out_cfg(rhc), .o_short_prot_en(pe), .o_short_prot_pwrdn(pd),
    .o_out_cm_sel(cm), .o_second_left_line_input_bypass(lb),
    .o_second_right_line_input_bypass(rb), .o_left_dac_path_sel(lpa),
    .o_right_dac_path_sel(rpa), .o_left_direct_trim_db(lt), .o_right_direct_trim_db(rt),
    .o_left_dac_vol(lv), .o_right_dac_vol(rv));
  // expected {refused, stored}; a forbidden code keeps the old field
  function automatic [8:0] upd(input [11:0] ad, input [7:0] o, input [7:0] d);
    logic e;
    logic f;
    e = d[7:6] == 2'h3;
    f = d[5:4] == 2'h3;
    case (ad)
      12'h094: upd = {f, d[7:6], f ? o[5:4] : d[5:4], 4'h0};
      12'h098: upd = {d[5:3] > 3'h4, 2'h0, d[5:3] > 3'h4 ? o[5:3] : d[5:3], d[2:1], 1'b0};
      12'h09c: upd = {1'b1, o};
      12'h0a0: upd = {d[1:0] == 2'h3, d[7:2], d[1:0] == 2'h3 ? o[1:0] : d[1:0]};
      12'h0a4: upd = {e | f, e ? o[7:6] : d[7:6], f ? o[5:4] : d[5:4], 2'h0, d[1:0]};
      default: upd = {2'h0, d[6:0]};
    endcase
  endfunction
  task automatic chk(input string n, input [63:0] e, input [63:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(input w, input [11:0] ad, input [31:0] d);
    @(posedge i_clk);
    i_psel <= 1;
    i_penable <= 0;
    i_pwrite <= w;
    i_paddr <= ad;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    i_psel <= 0;
    i_penable <= 0;
  endtask
  task automatic wr(input [11:0] ad, input [7:0] d);
    u = upd(ad, m[ad[11:2] - 10'h25], d);
    q.push_back({u[8], 32'h0});
    apb(1, ad, {r[31:8], d});
    m[ad[11:2] - 10'h25] = u[7:0];
    if (ad == 12'h09c) hit = 1'b1;
  endtask
  task automatic rd(input [11:0] ad, input [32:0] e);
    q.push_back(e);
    apb(0, ad, r);
  endtask
  task automatic outs;
    @(posedge i_clk);
    #1 chk("cfg", {m[0][7:4], m[1][5:2], m[1][2] & m[1][1], m[3][7:2], m[4][7:4],
      7'h0, m[4][7:6] == 2'h2, 7'h0, m[4][5:4] == 2'h2},
      {lp, rp, lhc, rhc, pe, pd, cm, lb, rb, lpa, rpa, lt, rt});
  endtask
  task automatic vol(input [6:0] l, input [6:0] rr);
    repeat (3) @(posedge i_clk);
    #1 chk("vol", {l, rr}, {lv, rv});
  endtask
  task automatic tick(input integer n);
    repeat (n) begin
      @(posedge i_clk);
      i_fs_tick <= 1;
      @(posedge i_clk);
      i_fs_tick <= 0;
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // the scoreboard pairs each completed transfer with the oldest note
  always @(posedge i_clk)
    if (i_psel && i_penable && o_pready === 1'b1)
      chk("apb", q.pop_front(), {o_pslverr, i_pwrite ? 32'h0 : o_prdata});
  initial begin
    #20000;
    fails++;
    print_verdict;
  end
  initial begin
    r = $random(seed);
    foreach (m[k]) m[k] = 8'h00;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 0;
    for (i = 0; i < 5; i++) rd(12'(12'h094 + 4 * i), 33'h0);
    outs;
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      a = 12'h094 + {r[10:8] % 3'h5, 2'h0};
      wr(a, r[7:0]);
      outs;
      rd(a, {25'h0, m[a[11:2] - 10'h25]});
    end
    rd(12'h000, {1'b1, 32'h0});
    rd(12'h0c4, {1'b1, 32'h0});
    wr(12'h0a0, 8'h02);
    wr(12'h0ac, 8'h20);
    wr(12'h0b0, 8'h10);
    wr(12'h0a4, 8'h00);
    vol(7'h20, 7'h10);
    for (i = 1; i < 4; i++) begin
      wr(12'h0a4, 8'(i));
      vol(i == 1 ? 7'h10 : 7'h20, i == 2 ? 7'h20 : 7'h10);
    end
    wr(12'h0a0, 8'h00);
    wr(12'h0ac, 8'h24);
    tick(3);
    vol(7'h23, 7'h10);
    wr(12'h0a0, 8'h01);
    wr(12'h0ac, 8'h20);
    tick(4);
    vol(7'h21, 7'h10);
    rd(12'h0c0, {17'h0, hit, 7'h21, 7'h10, 1'b0});
    i_sys_rst <= 1;
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 0;
    foreach (m[k]) m[k] = 8'h00;
    outs;
    rd(12'h0a4, 33'h0);
    print_verdict;
  end
endmodule
bind dacr_regs dacr_regs_asserts i_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_left_dac_pwr(o_left_dac_pwr), .o_right_dac_pwr(o_right_dac_pwr),
  .o_short_prot_en(o_short_prot_en), .o_short_prot_pwrdn(o_short_prot_pwrdn),
  .o_left_dac_path_sel(o_left_dac_path_sel), .o_left_direct_trim_db(o_left_direct_trim_db));
`default_nettype wire
